// ### design/ddr4_write_ctrl.sv
// write controller end: command spacing, strobes, data and status
`timescale 1ns/1ps
module ddr4_write_ctrl #(
  parameter int W = 8,
  parameter int HALF_DIV = 4,
  parameter int MAX_WL = ddr4_wr_pkg::MAX_WL,
  parameter logic [3:0] CCD_L = 4'h5,
  parameter logic [7:0] TWTR_S = 8'h03,
  parameter logic [7:0] TWTR_L = 8'h09,
  parameter logic [7:0] TWR = 8'h0c
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ddr4_wr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  ddr4_link_if.ctrl link
);
  localparam int IW = $clog2(MAX_WL);
  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

  logic [1:0] cfg_burst;
  logic cfg_pre2t;
  logic [ddr4_wr_pkg::LAT_W-1:0] cfg_cwl, cfg_al;
  logic [2*W-1:0] seed;
  logic pending, pend_a12;
  logic [1:0] pend_bg;
  logic [9:0] pend_col;
  logic [7:0] div_cnt;
  logic [3:0] hold_cnt, gap;
  logic [1:0] last_bg;
  logic [MAX_WL-1:0] dl_v, live;
  ddr4_wr_pkg::wr_ent_t dl_e [MAX_WL];
  logic [2:0] pair_left;
  logic [2:0] pair_idx;
  logic [7:0] wtr_cnt;
  logic tick, issue, cwl_raised, start, drive_last;
  logic busy, rd_ok_other, rd_ok_same, wr_done;
  logic [ddr4_wr_pkg::LAT_W-1:0] cwl_eff;
  logic [ddr4_wr_pkg::WL_W-1:0] wl;
  logic [IW-1:0] i_data, i_pre1, i_pre2;
  logic [3:0] need;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_burst <= ddr4_wr_pkg::CFG_BURST_RST;
      cfg_pre2t <= 1'b0;
      cfg_cwl <= ddr4_wr_pkg::CFG_CWL_RST;
      cfg_al <= ddr4_wr_pkg::CFG_AL_RST;
    end else if (reg_write && reg_addr == ddr4_wr_pkg::REG_CFG) begin
      cfg_burst <= reg_wdata[ddr4_wr_pkg::CFG_BURST_LSB +: 2];
      cfg_pre2t <= reg_wdata[ddr4_wr_pkg::CFG_PRE2T];
      cfg_cwl <= reg_wdata[ddr4_wr_pkg::CFG_CWL_LSB +: ddr4_wr_pkg::LAT_W];
      cfg_al <= reg_wdata[ddr4_wr_pkg::CFG_AL_LSB +: ddr4_wr_pkg::LAT_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seed <= '0;
    end else if (reg_write && reg_addr == ddr4_wr_pkg::REG_SEED) begin
      seed <= reg_wdata[2*W-1:0];
    end
  end

  // a command written while one is still pending is dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pending <= 1'b0;
      pend_a12 <= 1'b0;
      pend_bg <= 2'h0;
      pend_col <= 10'h000;
    end else if (issue) begin
      pending <= 1'b0;
    end else if (reg_write && reg_addr == ddr4_wr_pkg::REG_CMD
                 && !pending) begin
      pending <= 1'b1;
      pend_a12 <= reg_wdata[ddr4_wr_pkg::CMD_A12];
      pend_bg <= reg_wdata[ddr4_wr_pkg::CMD_BG_LSB +: 2];
      pend_col <= reg_wdata[ddr4_wr_pkg::CMD_COL_LSB +: 10];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_read && reg_addr == ddr4_wr_pkg::REG_STATUS) begin
      reg_rdata <= 32'h0;
      reg_rdata[ddr4_wr_pkg::ST_PENDING] <= pending;
      reg_rdata[ddr4_wr_pkg::ST_BUSY] <= busy;
      reg_rdata[ddr4_wr_pkg::ST_CWL_RAISED] <= cwl_raised;
      reg_rdata[ddr4_wr_pkg::ST_WR_DONE] <= wr_done;
      reg_rdata[ddr4_wr_pkg::ST_RD_OTHER] <= rd_ok_other;
      reg_rdata[ddr4_wr_pkg::ST_RD_SAME] <= rd_ok_same;
      reg_rdata[ddr4_wr_pkg::ST_LAST_BG +: 2] <= last_bg;
    end else if (reg_read && reg_addr == ddr4_wr_pkg::REG_CFG) begin
      reg_rdata <= 32'h0;
      reg_rdata[ddr4_wr_pkg::CFG_BURST_LSB +: 2] <= cfg_burst;
      reg_rdata[ddr4_wr_pkg::CFG_PRE2T] <= cfg_pre2t;
      reg_rdata[ddr4_wr_pkg::CFG_CWL_LSB +: ddr4_wr_pkg::LAT_W] <= cfg_cwl;
      reg_rdata[ddr4_wr_pkg::CFG_AL_LSB +: ddr4_wr_pkg::LAT_W] <= cfg_al;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // link clock divider and link reset
  // ----------------------------------------------------------------
  // link outputs change on the falling half so the device sees them
  // a half period before its rising edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt <= 8'h00;
      link.ck <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= 8'h00;
      link.ck <= !link.ck;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign tick = (div_cnt == DIV_LAST) && link.ck;

  // the device reset needs running link clocks to be seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_cnt <= 4'h0;
      link.reset_n <= 1'b0;
    end else if (tick && hold_cnt != ddr4_wr_pkg::RST_HOLD_CK) begin
      hold_cnt <= hold_cnt + 4'h1;
    end else if (hold_cnt == ddr4_wr_pkg::RST_HOLD_CK) begin
      link.reset_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // latency and command spacing
  // ----------------------------------------------------------------
  always_comb begin
    cwl_raised = cfg_pre2t && cfg_cwl <= ddr4_wr_pkg::CWL_MIN;
    cwl_eff = cwl_raised ? ddr4_wr_pkg::CWL_MIN + 5'h01 : cfg_cwl;
    wl = ddr4_wr_pkg::WL_W'(cfg_al) + ddr4_wr_pkg::WL_W'(cwl_eff);
    i_data = IW'(wl - 7'h01);
    i_pre1 = IW'(wl - 7'h02);
    i_pre2 = IW'(wl - 7'h03);
    need = (pend_bg == last_bg) ? CCD_L : ddr4_wr_pkg::CCD_S;
  end

  assign issue = tick && pending && link.reset_n && gap >= need
                 && !(cfg_pre2t && gap == ddr4_wr_pkg::CCD_2T_BAD);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap <= ddr4_wr_pkg::GAP_MAX;
      last_bg <= 2'h0;
    end else if (issue) begin
      gap <= 4'h1;
      last_bg <= pend_bg;
    end else if (tick && gap != ddr4_wr_pkg::GAP_MAX) begin
      gap <= gap + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.wr_cmd <= 1'b0;
      link.a12 <= 1'b0;
      link.bg <= 2'h0;
      link.col <= 10'h000;
    end else if (tick) begin
      link.wr_cmd <= issue;
      link.a12 <= issue ? pend_a12 : 1'b0;
      link.bg <= issue ? pend_bg : 2'h0;
      link.col <= issue ? pend_col : 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // data and strobe scheduling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dl_v <= '0;
    end else if (tick) begin
      dl_v <= {dl_v[MAX_WL-2:0], issue};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (tick) begin
      dl_e[0] <= '{chop: ddr4_wr_pkg::is_chop(cfg_burst, pend_a12),
                   bg: pend_bg, col: pend_col};
      for (int i = 1; i < MAX_WL; i++) begin
        dl_e[i] <= dl_e[i-1];
      end
    end
  end

  assign start = dl_v[i_data];
  assign drive_last = tick && (start ? (ddr4_wr_pkg::pairs_of(
                      dl_e[i_data].chop) == 3'h1) : (pair_left == 3'h1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pair_left <= 3'h0;
      pair_idx <= 3'h0;
    end else if (tick && start) begin
      pair_left <= ddr4_wr_pkg::pairs_of(dl_e[i_data].chop) - 3'h1;
      pair_idx <= 3'h1;
    end else if (tick && pair_left != 3'h0) begin
      pair_left <= pair_left - 3'h1;
      pair_idx <= pair_idx + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.dq <= '0;
      link.dqs <= 1'b0;
    end else if (tick) begin
      link.dq <= start ? seed : seed + (2*W)'(pair_idx);
      link.dqs <= start || pair_left != 3'h0 || dl_v[i_pre1]
                  || (cfg_pre2t && dl_v[i_pre2]);
    end
  end

  // ----------------------------------------------------------------
  // write recovery and write-to-read status
  // ----------------------------------------------------------------
  // count is zero at the rising edge that captures the last data pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wtr_cnt <= 8'hff;
    end else if (drive_last) begin
      wtr_cnt <= 8'h00;
    end else if (tick && wtr_cnt != 8'hff) begin
      wtr_cnt <= wtr_cnt + 8'h01;
    end
  end

  always_comb begin
    // command bits past the data point only age out; they are not work
    live = dl_v & ~({MAX_WL{1'b1}} << wl);
    busy = (|live) || pair_left != 3'h0 || pending;
    wr_done = !busy && wtr_cnt >= TWR;
    // a sum one bit wider keeps a large additive latency from wrapping
    rd_ok_other = !busy && ({1'b0, wtr_cnt} + 9'(cfg_al)
                  >= 9'(TWTR_S));
    rd_ok_same = !busy && ({1'b0, wtr_cnt} + 9'(cfg_al)
                 >= 9'(TWTR_L));
  end
endmodule : ddr4_write_ctrl

// ### design/ddr4_wr_pkg.sv
// shared constants, types and helpers for the write-burst link
package ddr4_wr_pkg;
  // ----------------------------------------------------------------
  // burst field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_BL8 = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_BC4 = 2'h2;
  // clocks per burst, two beats in each clock
  localparam logic [2:0] PAIRS_BL8 = 3'h4;
  localparam logic [2:0] PAIRS_BC4 = 3'h2;
  // ----------------------------------------------------------------
  // link timing in clocks of the link
  // ----------------------------------------------------------------
  localparam logic [3:0] CCD_S = 4'h4;
  localparam logic [3:0] CCD_2T_BAD = 4'h5;
  localparam logic [3:0] GAP_MAX = 4'hf;
  localparam int LAT_W = 5;
  localparam logic [LAT_W-1:0] CWL_MIN = 5'h09;
  localparam int MAX_WL = 64;
  localparam int WL_W = 7;
  localparam logic [3:0] RST_HOLD_CK = 4'h8;
  // ----------------------------------------------------------------
  // register map of the controller
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_SEED = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CFG_BURST_LSB = 0;
  localparam int CFG_PRE2T = 2;
  localparam int CFG_CWL_LSB = 4;
  localparam int CFG_AL_LSB = 10;
  localparam int CMD_COL_LSB = 0;
  localparam int CMD_BG_LSB = 10;
  localparam int CMD_A12 = 12;
  localparam int ST_PENDING = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_CWL_RAISED = 2;
  localparam int ST_WR_DONE = 3;
  localparam int ST_RD_OTHER = 4;
  localparam int ST_RD_SAME = 5;
  localparam int ST_LAST_BG = 6;
  localparam logic [1:0] CFG_BURST_RST = BURST_BL8;
  localparam logic [LAT_W-1:0] CFG_CWL_RST = CWL_MIN;
  localparam logic [LAT_W-1:0] CFG_AL_RST = 5'h00;

  typedef struct packed {
    logic chop;
    logic [1:0] bg;
    logic [9:0] col;
  } wr_ent_t;

  function automatic logic is_chop(input logic [1:0] mode,
                                   input logic a12);
    is_chop = (mode == BURST_BC4) || (mode == BURST_OTF && !a12);
  endfunction : is_chop

  function automatic logic [2:0] pairs_of(input logic chop);
    pairs_of = chop ? PAIRS_BC4 : PAIRS_BL8;
  endfunction : pairs_of
endpackage : ddr4_wr_pkg

// ### design/ddr4_link_if.sv
// link between the write controller and the memory device
`timescale 1ns/1ps
interface ddr4_link_if #(parameter int W = 8);
  logic ck;
  logic reset_n;
  logic wr_cmd;
  logic a12;
  logic [1:0] bg;
  logic [9:0] col;
  logic dqs;
  logic [2*W-1:0] dq;

  modport ctrl(output ck, reset_n, wr_cmd, a12, bg, col, dqs, dq);
  modport dev(input ck, reset_n, wr_cmd, a12, bg, col, dqs, dq);
endinterface : ddr4_link_if

// ### design/ddr4_write_device.sv
// memory device end: write latency, burst length and beat capture
`timescale 1ns/1ps
module ddr4_write_device #(
  parameter int W = 8,
  parameter int MAX_WL = ddr4_wr_pkg::MAX_WL
) (
  ddr4_link_if.dev link,
  input wire logic [1:0] burst_mode,
  input wire logic preamble_2t,
  input wire logic [ddr4_wr_pkg::LAT_W-1:0] al,
  input wire logic [ddr4_wr_pkg::LAT_W-1:0] cwl,
  output logic beat_valid,
  output logic [2*W-1:0] beat_pair,
  output logic [1:0] beat_bg,
  output logic [9:0] beat_col,
  output logic [2:0] beat_index,
  output logic burst_end,
  output logic preamble_err
);
  localparam int IW = $clog2(MAX_WL);

  logic rst_meta;
  logic rst_sync;
  logic [MAX_WL-1:0] dl_v;
  ddr4_wr_pkg::wr_ent_t dl_e [MAX_WL];
  ddr4_wr_pkg::wr_ent_t cur;
  logic [2:0] pair_left;
  logic [ddr4_wr_pkg::WL_W-1:0] wl;
  logic [IW-1:0] i_data;
  logic [IW-1:0] i_pre1;
  logic [IW-1:0] i_pre2;
  logic start;
  logic cap;

  // ----------------------------------------------------------------
  // reset pin crossing
  // ----------------------------------------------------------------
  always_ff @(posedge link.ck) begin
    rst_meta <= !link.reset_n;
    rst_sync <= rst_meta;
  end

  // ----------------------------------------------------------------
  // write latency delay line
  // ----------------------------------------------------------------
  always_comb begin
    wl = ddr4_wr_pkg::WL_W'(al) + ddr4_wr_pkg::WL_W'(cwl);
    i_data = IW'(wl - 7'h01);
    i_pre1 = IW'(wl - 7'h02);
    i_pre2 = IW'(wl - 7'h03);
  end

  always_ff @(posedge link.ck) begin
    if (rst_sync) begin
      dl_v <= '0;
    end else begin
      dl_v <= {dl_v[MAX_WL-2:0], link.wr_cmd};
    end
  end

  // burst length is fixed when the command is taken, not at data time
  always_ff @(posedge link.ck) begin
    dl_e[0] <= '{chop: ddr4_wr_pkg::is_chop(burst_mode, link.a12),
                 bg: link.bg, col: link.col};
    for (int i = 1; i < MAX_WL; i++) begin
      dl_e[i] <= dl_e[i-1];
    end
  end

  assign start = dl_v[i_data];
  assign cap = start || (pair_left != 3'h0);

  // ----------------------------------------------------------------
  // burst capture, two beats per clock
  // ----------------------------------------------------------------
  // a new start replaces a finishing burst, so gapless bursts just chain
  always_ff @(posedge link.ck) begin
    if (rst_sync) begin
      pair_left <= 3'h0;
    end else if (start) begin
      pair_left <= ddr4_wr_pkg::pairs_of(dl_e[i_data].chop) - 3'h1;
    end else if (pair_left != 3'h0) begin
      pair_left <= pair_left - 3'h1;
    end
  end

  always_ff @(posedge link.ck) begin
    if (rst_sync) begin
      cur <= '0;
    end else if (start) begin
      cur <= dl_e[i_data];
    end
  end

  always_ff @(posedge link.ck) begin
    if (rst_sync) begin
      beat_valid <= 1'b0;
      beat_pair <= '0;
      beat_bg <= 2'h0;
      beat_col <= 10'h000;
      beat_index <= 3'h0;
      burst_end <= 1'b0;
    end else begin
      beat_valid <= cap;
      beat_pair <= cap ? link.dq : beat_pair;
      beat_bg <= start ? dl_e[i_data].bg : cur.bg;
      beat_col <= start ? dl_e[i_data].col : cur.col;
      beat_index <= start ? 3'h0 : (cap ? beat_index + 3'h1 : 3'h0);
      burst_end <= start ? (ddr4_wr_pkg::pairs_of(dl_e[i_data].chop)
                            == 3'h1) : (pair_left == 3'h1);
    end
  end

  // ----------------------------------------------------------------
  // strobe preamble check
  // ----------------------------------------------------------------
  // each burst needs its own preamble unless data runs gapless
  always_ff @(posedge link.ck) begin
    if (rst_sync) begin
      preamble_err <= 1'b0;
    end else if ((dl_v[i_pre1] || (preamble_2t && dl_v[i_pre2]) || cap)
                 && !link.dqs) begin
      preamble_err <= 1'b1;
    end
  end
endmodule : ddr4_write_device

// ### bench/ddr4_link_asserts.sv
// link-level assertions for the write-burst link
`timescale 1ns/1ps
module ddr4_link_asserts #(
  parameter int W = 8
) (
  input wire logic ck,
  input wire logic reset_n,
  input wire logic wr_cmd,
  input wire logic a12,
  input wire logic [1:0] bg,
  input wire logic [9:0] col,
  input wire logic dqs,
  input wire logic [2*W-1:0] dq
);
  default clocking cb @(posedge ck); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // link clocks since the last command, saturating
  // ----------------------------------------------------------------
  logic [7:0] since;
  always_ff @(posedge ck) begin
    if (!reset_n) begin
      since <= 8'hff;
    end else if (wr_cmd) begin
      since <= 8'h01;
    end else if (since != 8'hff) begin
      since <= since + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_cmd_pulse;
    wr_cmd |=> !wr_cmd;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command held longer than one clock");
  property p_cmd_gap;
    wr_cmd |=> !wr_cmd [*3];
  endproperty
  a_cmd_gap: assert property (p_cmd_gap)
    else $error("commands closer than four clocks");
  property p_idle_addr;
    !wr_cmd |-> !a12 && bg == 2'h0 && col == 10'h000;
  endproperty
  a_idle_addr: assert property (p_idle_addr)
    else $error("address lines busy on a deselect clock");
  property p_cmd_after_reset;
    $rose(reset_n) |-> !wr_cmd;
  endproperty
  a_cmd_after_reset: assert property (p_cmd_after_reset)
    else $error("command together with reset release");
  property p_wl;
    wr_cmd |-> ##[8:80] dqs;
  endproperty
  a_wl: assert property (p_wl)
    else $error("no strobe after a command");
  property p_burst_min;
    $rose(dqs) |-> dqs [*3];
  endproperty
  a_burst_min: assert property (p_burst_min)
    else $error("strobe burst shorter than preamble plus two pairs");
  property p_tail;
    $fell(dqs) |-> $past(dqs, 3);
  endproperty
  a_tail: assert property (p_tail)
    else $error("strobe dropped too early");
  property p_dqs_cause;
    dqs |-> since <= 8'd70;
  endproperty
  a_dqs_cause: assert property (p_dqs_cause)
    else $error("strobe without a recent command");
  c_gapless: cover property (wr_cmd ##4 wr_cmd);
  c_gap6: cover property (wr_cmd ##6 wr_cmd);
  c_chop: cover property ($rose(dqs) ##3 !dqs);
endmodule : ddr4_link_asserts

// ### bench/tb_top.sv
// top-level bench for the write-burst link
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // clocks, ends and checker
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] bm = 2'h0;
  logic p2 = 1'b0;
  logic [4:0] al_d = 5'h00;
  logic [4:0] cw_d = 5'h09;
  logic beat_valid, beat_end, err, err_b;
  logic [15:0] beat_pair;
  logic [1:0] beat_bg;
  logic [9:0] beat_col;
  logic [2:0] beat_index;
  int n_mismatch = 0;
  int num_checks = 0;
  always #4 clk_sys = ~clk_sys;
  ddr4_link_if #(.W(8)) lk();
  ddr4_link_if #(.W(8)) lf();
  ddr4_write_ctrl #(.W(8)) u_ddr4_write_ctrl(.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .link(lk.ctrl));
  ddr4_write_device #(.W(8)) u_ddr4_write_device(.link(lk.dev),
    .burst_mode(bm), .preamble_2t(p2), .al(al_d), .cwl(cw_d),
    .beat_valid(beat_valid), .beat_pair(beat_pair), .beat_bg(beat_bg),
    .beat_col(beat_col), .beat_index(beat_index), .burst_end(beat_end),
    .preamble_err(err));
  // second device faces a bench driver that never raises the strobe
  ddr4_write_device u_ddr4_write_device_b(.link(lf.dev),
    .burst_mode(bm), .preamble_2t(p2), .al(al_d), .cwl(cw_d),
    .beat_valid(), .beat_pair(), .beat_bg(), .beat_col(), .beat_index(),
    .burst_end(), .preamble_err(err_b));
  ddr4_link_asserts u_ddr4_link_asserts(.ck(lk.ck),
    .reset_n(lk.reset_n), .wr_cmd(lk.wr_cmd), .a12(lk.a12), .bg(lk.bg),
    .col(lk.col), .dqs(lk.dqs), .dq(lk.dq));
  // ----------------------------------------------------------------
  // link monitor: spacing, latency, strobe start, captured beats
  // ----------------------------------------------------------------
  logic [7:0] since = 8'h00;
  logic [7:0] run = 8'h00;
  logic [7:0] maxrun = 8'h00;
  logic [7:0] gap, wl_seen, rise_at;
  logic armed = 1'b0;
  logic dqs_d = 1'b0;
  logic [31:0] got[$];
  always @(posedge lk.ck) begin
    since <= lk.wr_cmd ? 8'h01 : since + 8'h01;
    dqs_d <= lk.dqs;
    run <= beat_valid ? run + 8'h01 : 8'h00;
    if (lk.wr_cmd) begin
      gap <= since;
      armed <= 1'b1;
    end
    if (lk.dqs && !dqs_d && armed) rise_at <= since;
    if (beat_valid && armed) begin
      wl_seen <= since;
      armed <= 1'b0;
    end
    if (beat_valid) begin
      got.push_back({beat_end, beat_index, beat_bg, beat_col, beat_pair});
      if (run + 8'h01 > maxrun) maxrun <= run + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] exp, input logic [31:0] act);
    num_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task bail(input logic hit);
    if (hit) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : bail
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task st(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(ddr4_wr_pkg::REG_STATUS, v);
    chk(e, v & m);
  endtask : st
  task wait_beats(input int n);
    int i;
    for (i = 0; i < 400 && got.size() < n; i++) @(posedge lk.ck);
    bail(i == 400);
    repeat (2) @(posedge lk.ck);
  endtask : wait_beats
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // one write; dup retries the command at once, which must be refused
  task run_one(input logic [1:0] b, input logic a, input logic p,
               input logic [4:0] al, input logic [9:0] c, input logic dup);
    int wl, n, k;
    logic [15:0] s;
    n = (b == 2'h2 || (b == 2'h1 && !a)) ? 2 : 4;
    wl = al + (p ? 10 : 9);
    s = {6'h00, c} ^ 16'ha5c0;
    bm <= b;
    p2 <= p;
    al_d <= al;
    cw_d <= p ? 5'h0a : 5'h09;
    wr(ddr4_wr_pkg::REG_CFG, {17'h0, al, 1'b0, 5'h09, 1'b0, p, b});
    wr(ddr4_wr_pkg::REG_SEED, {16'h0, s});
    got.delete();
    // a retry right behind the command meets pending and is dropped
    @(posedge clk_sys);
    reg_addr <= ddr4_wr_pkg::REG_CMD;
    reg_wdata <= {19'h0, a, c[1:0], c};
    reg_write <= 1'b1;
    if (dup) begin
      @(posedge clk_sys);
      reg_wdata <= {19'h0, !a, ~c[1:0], ~c};
    end
    @(posedge clk_sys);
    reg_write <= 1'b0;
    wait_beats(n);
    chk(32'(n), 32'(got.size()));
    for (k = 0; k < n; k++) begin
      chk({k == n - 1, 3'(k), c[1:0], c, s + 16'(k)}, got[k]);
    end
    chk(32'(wl + 1), {24'h0, wl_seen});
    chk(32'(wl - 1 - p), {24'h0, rise_at});
    chk(32'h0, {31'h0, err});
    st(32'hc0, {24'h0, c[1:0], 6'h00});
  endtask : run_one
  task run_two(input logic p, input logic [1:0] b2);
    int i, need;
    logic [31:0] v;
    need = (b2 != 2'h0) ? 4 : (p ? 6 : 5);
    bm <= 2'h0;
    p2 <= p;
    al_d <= 5'h00;
    cw_d <= p ? 5'h0a : 5'h09;
    wr(ddr4_wr_pkg::REG_CFG, {23'h0, 5'h09, 1'b0, p, 2'h0});
    got.delete();
    maxrun = 8'h00;
    wr(ddr4_wr_pkg::REG_CMD, 32'h0000_0010);
    v = 32'h1;
    for (i = 0; i < 100 && v[0]; i++) rd(ddr4_wr_pkg::REG_STATUS, v);
    bail(i == 100);
    wr(ddr4_wr_pkg::REG_CMD, {20'h0, b2, 10'h020});
    wait_beats(8);
    chk(32'(need), {24'h0, gap});
    chk(32'h0, 32'(p && gap == 8'h05));
    chk(gap == 8'h04 ? 32'h8 : 32'h4, {24'h0, maxrun});
    chk(32'h0, {31'h0, err});
  endtask : run_two
  // clock of the faulty link only runs while the driver sends
  task tick2;
    #62.5 lf.ck = 1'b1;
    #62.5 lf.ck = 1'b0;
  endtask : tick2
  task s_fault;
    repeat (4) tick2;
    lf.reset_n = 1'b1;
    repeat (3) tick2;
    lf.wr_cmd = 1'b1;
    tick2;
    lf.wr_cmd = 1'b0;
    repeat (14) begin
      lf.dq = ~lf.dq;
      tick2;
    end
    chk(32'h1, {31'h0, err_b});
  endtask : s_fault
  task s_wtr;
    run_one(2'h0, 1'b1, 1'b0, 5'h00, 10'h203, 1'b0);
    st(32'h28, 32'h00);
    repeat (3) @(posedge lk.ck);
    st(32'h38, 32'h10);
    repeat (12) @(posedge lk.ck);
    st(32'hff, 32'hf8);
    run_one(2'h1, 1'b1, 1'b0, 5'h0a, 10'h001, 1'b0);
    st(32'h28, 32'h20);
  endtask : s_wtr
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int i;
    lf.ck = 1'b0;
    lf.reset_n = 1'b0;
    lf.wr_cmd = 1'b0;
    lf.a12 = 1'b0;
    lf.bg = 2'h0;
    lf.col = 10'h000;
    lf.dqs = 1'b0;
    lf.dq = 16'h00ff;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 2000 && lk.reset_n !== 1'b1; i++) @(posedge clk_sys);
    bail(i == 2000);
    rd(ddr4_wr_pkg::REG_CFG, v);
    chk(32'h0000_0090, v);
    rd(8'h10, v);
    chk(32'h0, v);
    s_fault;
    for (i = 0; i < 4; i++) begin
      run_one(i == 0 ? 2'h0 : (i == 3 ? 2'h2 : 2'h1), i[0], 1'b0, 5'h00,
              10'(i * 9 + 64), i == 2);
    end
    run_one(2'h1, 1'b0, 1'b1, 5'h00, 10'h102, 1'b0);
    st(32'h4, 32'h4);
    s_wtr;
    run_two(1'b0, 2'h2);
    run_two(1'b0, 2'h0);
    run_two(1'b1, 2'h0);
    run_two(1'b1, 2'h1);
    end_of_test;
  end
endmodule : tb_top
